// [pkg/two_wire_pkg.sv]
// two-wire register port: shared constants, state encodings and timing counts
// assumes one 10 MHz system clock on both ends and external pull-ups on both lines
package two_wire_pkg;

    // bus addresses, direction bit excluded
    localparam logic [6:0] SLAVE_ADDR_SEL_LOW  = 7'h6e;
    localparam logic [6:0] SLAVE_ADDR_SEL_HIGH = 7'h6f;
    localparam logic       DIR_READ            = 1'h1;

    // bit slot numbering: 0..7 data, 8 acknowledge
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    // register space
    localparam int unsigned NUM_REGS_DEF = 256;

    // timing: each clock period of the line is four quarter steps
    localparam int unsigned CLK_FREQ_KHZ = 10000;
    localparam int unsigned SCL_FREQ_KHZ = 400;
    // rounded up so the line rate never exceeds the limit
    localparam int unsigned QTR_CYC = (CLK_FREQ_KHZ + 4 * SCL_FREQ_KHZ - 1) / (4 * SCL_FREQ_KHZ);

    typedef enum logic [3:0] {
        S_IDLE    = 4'h0,
        S_DEV     = 4'h1,
        S_DEV_ACK = 4'h3,
        S_REG     = 4'h2,
        S_REG_ACK = 4'h6,
        S_WR      = 4'h7,
        S_WR_ACK  = 4'h5,
        S_RD      = 4'h4,
        S_RD_ACK  = 4'hc,
        S_SKIP    = 4'hd
    } slave_st_type;

    typedef enum logic [1:0] {
        M_IDLE  = 2'h0,
        M_START = 2'h1,
        M_BIT   = 2'h3,
        M_STOP  = 2'h2
    } master_st_type;

    typedef enum logic [2:0] {
        G_DEVW  = 3'h0,
        G_REG   = 3'h1,
        G_WDATA = 3'h3,
        G_DEVR  = 3'h2,
        G_RDATA = 3'h6
    } stage_type;

endpackage

// [pkg/two_wire_if.sv]
// two-wire bus carrier: resolves the data line from both ends' enables and the clock line from the master's alone
// assumes external pull-ups; no clocking block, pure wiring
`timescale 1ns/1ps
interface two_wire_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;

    // wired-and with pull-up: an enabled low wins
    assign scl = !(m_scl_oe && !m_scl_o);
    assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

    modport master (
        output m_scl_o,
        output m_scl_oe,
        output m_sda_o,
        output m_sda_oe,
        input  scl,
        input  sda
    );

    modport slave (
        output s_sda_o,
        output s_sda_oe,
        input  scl,
        input  sda
    );
endinterface

// [hw/two_wire_slave.sv]
// device end of the two-wire register port: decodes frames and drives register strobes
// assumes the register file answers REG_RDATA_I for REG_ADDR_O in the same clock domain
`timescale 1ns/1ps
module two_wire_slave #(
    parameter int unsigned NUM_REGS = two_wire_pkg::NUM_REGS_DEF
) (
    // clock and reset
    input  wire logic       CLK_I,
    input  wire logic       RST_B_I,
    // bus
    two_wire_if.slave       BUS,
    // address strap pin
    input  wire logic       SLAVE_ADDRESS_SELECT_PIN_I,
    // register file side
    output logic [7:0]      REG_ADDR_O,
    output logic [7:0]      REG_WDATA_O,
    output logic            REG_WE_O,
    input  wire logic [7:0] REG_RDATA_I
);

    // refused at elaboration: an 8-bit register address reaches 256 registers at most
    if (NUM_REGS < 1 || NUM_REGS > 256) begin : g_regs_chk
        $error("NUM_REGS must lie in 1..256");
    end

    localparam logic [8:0] REG_LIMIT = 9'(NUM_REGS);

    typedef struct packed {
        two_wire_pkg::slave_st_type st;
        logic [3:0]                 cnt;
        logic [7:0]                 sh;
        logic [7:0]                 addr;
        logic                       rd_ack;
        logic                       sda_oe;
        logic                       we;
        logic [7:0]                 wdata;
        logic [2:0]                 scl_sy;
        logic [2:0]                 sda_sy;
        logic [1:0]                 sel_sy;
    } slave_state_type;

    slave_state_type r;
    slave_state_type n;

    logic       scl_hi;
    logic       scl_rise;
    logic       scl_fall;
    logic       sda_s;
    logic       start_det;
    logic       stop_det;
    logic [6:0] own_addr;

    // index [1] is the second synchroniser stage, [2] its delayed copy for edges
    assign scl_hi    = r.scl_sy[1];
    assign scl_rise  = r.scl_sy[1] && !r.scl_sy[2];
    assign scl_fall  = !r.scl_sy[1] && r.scl_sy[2];
    assign sda_s     = r.sda_sy[1];
    // clock must be high on both samples so a data edge near a clock edge is not misread
    assign start_det = scl_hi && r.scl_sy[2] && !sda_s && r.sda_sy[2];
    assign stop_det  = scl_hi && r.scl_sy[2] && sda_s && !r.sda_sy[2];
    assign own_addr  = r.sel_sy[1] ? two_wire_pkg::SLAVE_ADDR_SEL_HIGH
                                   : two_wire_pkg::SLAVE_ADDR_SEL_LOW;

    function automatic logic in_range(input logic [7:0] a);
        in_range = {1'h0, a} < REG_LIMIT;
    endfunction

    always_comb begin
        n        = r;
        n.we     = 1'h0;
        n.scl_sy = {r.scl_sy[1:0], BUS.scl};
        n.sda_sy = {r.sda_sy[1:0], BUS.sda};
        n.sel_sy = {r.sel_sy[0], SLAVE_ADDRESS_SELECT_PIN_I};

        if (start_det) begin
            // a repeated start keeps the register address
            n.st     = two_wire_pkg::S_DEV;
            n.cnt    = 4'h0;
            n.sda_oe = 1'h0;
        end else if (stop_det) begin
            n.st     = two_wire_pkg::S_IDLE;
            n.sda_oe = 1'h0;
        end else begin
            case (r.st)
                two_wire_pkg::S_DEV,
                two_wire_pkg::S_REG,
                two_wire_pkg::S_WR: begin
                    if (scl_rise) begin
                        // msb arrives first
                        n.sh  = {r.sh[6:0], sda_s};
                        n.cnt = r.cnt + 4'h1;
                    end else if (scl_fall && r.cnt == two_wire_pkg::ACK_SLOT) begin
                        // ack driven only after the clock has gone low
                        case (r.st)
                            two_wire_pkg::S_DEV: begin
                                if (r.sh[7:1] == own_addr) begin
                                    n.st     = two_wire_pkg::S_DEV_ACK;
                                    n.sda_oe = 1'h1;
                                end else begin
                                    n.st = two_wire_pkg::S_SKIP;
                                end
                            end
                            two_wire_pkg::S_REG: begin
                                n.addr   = r.sh;
                                n.st     = two_wire_pkg::S_REG_ACK;
                                n.sda_oe = 1'h1;
                            end
                            default: begin
                                // out-of-range bytes are acked but never reach the register file
                                n.we     = in_range(r.addr);
                                n.wdata  = r.sh;
                                n.st     = two_wire_pkg::S_WR_ACK;
                                n.sda_oe = 1'h1;
                            end
                        endcase
                    end
                end
                two_wire_pkg::S_DEV_ACK: begin
                    if (scl_fall) begin
                        n.cnt = 4'h0;
                        if (r.sh[0] == two_wire_pkg::DIR_READ) begin
                            n.st     = two_wire_pkg::S_RD;
                            n.sh     = REG_RDATA_I;
                            n.sda_oe = !REG_RDATA_I[7];
                        end else begin
                            n.st     = two_wire_pkg::S_REG;
                            n.sda_oe = 1'h0;
                        end
                    end
                end
                two_wire_pkg::S_REG_ACK: begin
                    if (scl_fall) begin
                        n.st     = two_wire_pkg::S_WR;
                        n.cnt    = 4'h0;
                        n.sda_oe = 1'h0;
                    end
                end
                two_wire_pkg::S_WR_ACK: begin
                    if (scl_fall) begin
                        n.st     = two_wire_pkg::S_WR;
                        n.cnt    = 4'h0;
                        n.sda_oe = 1'h0;
                        n.addr   = r.addr + 8'h01;
                    end
                end
                two_wire_pkg::S_RD: begin
                    if (scl_fall) begin
                        if (r.cnt == two_wire_pkg::LAST_BIT) begin
                            // release for the master's ack slot
                            n.st     = two_wire_pkg::S_RD_ACK;
                            n.sda_oe = 1'h0;
                            n.addr   = r.addr + 8'h01;
                        end else begin
                            // new bit only while the clock is low
                            n.cnt    = r.cnt + 4'h1;
                            n.sh     = {r.sh[6:0], 1'h0};
                            n.sda_oe = !r.sh[6];
                        end
                    end
                end
                two_wire_pkg::S_RD_ACK: begin
                    if (scl_rise) begin
                        n.rd_ack = !sda_s;
                    end else if (scl_fall) begin
                        if (r.rd_ack) begin
                            n.st     = two_wire_pkg::S_RD;
                            n.cnt    = 4'h0;
                            n.sh     = REG_RDATA_I;
                            n.sda_oe = !REG_RDATA_I[7];
                        end else begin
                            // nack ends the read; stay off the bus until start or stop
                            n.st = two_wire_pkg::S_SKIP;
                        end
                    end
                end
                two_wire_pkg::S_IDLE,
                two_wire_pkg::S_SKIP: begin
                    n.sda_oe = 1'h0;
                end
                default: begin
                    n.st     = two_wire_pkg::S_IDLE;
                    n.sda_oe = 1'h0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            r <= '{st: two_wire_pkg::S_IDLE, cnt: 4'h0, sh: 8'h00, addr: 8'h00, rd_ack: 1'h0,
                   sda_oe: 1'h0, we: 1'h0, wdata: 8'h00, scl_sy: 3'h7, sda_sy: 3'h7, sel_sy: 2'h0};
        end else begin
            r <= n;
        end
    end

    // only ever pulls low; the high level comes from the pull-up
    assign BUS.s_sda_o  = 1'h0;
    assign BUS.s_sda_oe = r.sda_oe;
    assign REG_ADDR_O   = r.addr;
    assign REG_WDATA_O  = r.wdata;
    assign REG_WE_O     = r.we;

endmodule

// [hw/two_wire_master.sv]
// host end of the two-wire register port: runs write and combined read frames
// assumes a slave that never stretches the clock
`timescale 1ns/1ps
module two_wire_master #(
    parameter int unsigned LEN_W = 4
) (
    // clock and reset
    input  wire logic             CLK_I,
    input  wire logic             RST_B_I,
    // bus
    two_wire_if.master            BUS,
    // command
    input  wire logic             CMD_START_I,
    input  wire logic             CMD_READ_I,
    input  wire logic [6:0]       CMD_DEV_I,
    input  wire logic [7:0]       CMD_REG_I,
    input  wire logic [LEN_W-1:0] CMD_LEN_I,
    // data
    input  wire logic [7:0]       WR_DATA_I,
    output logic                  WR_TAKE_O,
    output logic [7:0]            RD_DATA_O,
    output logic                  RD_VALID_O,
    // status
    output logic                  BUSY_O,
    output logic                  DONE_O,
    output logic                  NACK_O
);

    // refused at elaboration
    if (LEN_W < 1 || LEN_W > 16) begin : g_len_chk
        $error("LEN_W must lie in 1..16");
    end

    localparam logic [7:0]       QTR_LAST = 8'(two_wire_pkg::QTR_CYC - 1);
    localparam logic [LEN_W-1:0] LEN_ONE  = LEN_W'(1);

    typedef struct packed {
        two_wire_pkg::master_st_type st;
        two_wire_pkg::stage_type     stage;
        logic [1:0]                  q;
        logic [7:0]                  div;
        logic [3:0]                  bitn;
        logic [7:0]                  sh;
        logic [LEN_W-1:0]            len;
        logic                        rd;
        logic [6:0]                  dev;
        logic [7:0]                  regn;
        logic                        nak;
        logic                        scl_oe;
        logic                        sda_oe;
        logic                        take;
        logic                        rvalid;
        logic [7:0]                  rdata;
        logic                        busy;
        logic                        done;
        logic                        nack;
        logic [1:0]                  sda_sy;
    } master_state_type;

    master_state_type r;
    master_state_type n;

    logic tick;
    logic rx;
    assign tick = r.div == QTR_LAST;
    assign rx   = r.stage == two_wire_pkg::G_RDATA;

    always_comb begin
        n        = r;
        n.take   = 1'h0;
        n.rvalid = 1'h0;
        n.done   = 1'h0;
        n.sda_sy = {r.sda_sy[0], BUS.sda};
        n.div    = (tick || r.st == two_wire_pkg::M_IDLE) ? 8'h00 : r.div + 8'h01;
        if (tick) begin
            n.q = r.q + 2'h1;
        end
        case (r.st)
            two_wire_pkg::M_IDLE: begin
                n.q = 2'h0;
                if (CMD_START_I) begin
                    n.st    = two_wire_pkg::M_START;
                    n.stage = two_wire_pkg::G_DEVW;
                    n.rd    = CMD_READ_I;
                    n.dev   = CMD_DEV_I;
                    n.regn  = CMD_REG_I;
                    n.len   = (CMD_LEN_I == '0) ? LEN_ONE : CMD_LEN_I;
                    n.busy  = 1'h1;
                    n.nack  = 1'h0;
                end
            end
            two_wire_pkg::M_START: begin
                // same sequence serves the first start and a repeated start
                if (tick) begin
                    case (r.q)
                        2'h0: n.sda_oe = 1'h0;
                        2'h1: n.scl_oe = 1'h0;
                        2'h2: n.sda_oe = 1'h1;
                        default: begin
                            n.scl_oe = 1'h1;
                            n.st     = two_wire_pkg::M_BIT;
                            n.bitn   = 4'h0;
                            n.sh     = {r.dev, r.stage == two_wire_pkg::G_DEVR};
                        end
                    endcase
                end
            end
            two_wire_pkg::M_BIT: begin
                if (tick) begin
                    case (r.q)
                        2'h0: begin
                            // data set while clock is low
                            if (r.bitn == two_wire_pkg::ACK_SLOT) begin
                                n.sda_oe = rx && r.len != LEN_ONE;
                            end else begin
                                n.sda_oe = !rx && !r.sh[7];
                            end
                        end
                        2'h1: n.scl_oe = 1'h0;
                        2'h2: begin
                            if (r.bitn == two_wire_pkg::ACK_SLOT) begin
                                n.nak = r.sda_sy[1];
                            end else begin
                                n.sh = {r.sh[6:0], r.sda_sy[1]};
                            end
                        end
                        default: begin
                            n.scl_oe = 1'h1;
                            n.bitn   = r.bitn + 4'h1;
                            if (r.bitn == two_wire_pkg::ACK_SLOT) begin
                                n.bitn = 4'h0;
                                if (!rx && r.nak) begin
                                    n.st   = two_wire_pkg::M_STOP;
                                    n.nack = 1'h1;
                                end else begin
                                    case (r.stage)
                                        two_wire_pkg::G_DEVW: begin
                                            n.stage = two_wire_pkg::G_REG;
                                            n.sh    = r.regn;
                                        end
                                        two_wire_pkg::G_REG: begin
                                            if (r.rd) begin
                                                n.st    = two_wire_pkg::M_START;
                                                n.stage = two_wire_pkg::G_DEVR;
                                            end else begin
                                                n.stage = two_wire_pkg::G_WDATA;
                                                n.sh    = WR_DATA_I;
                                                n.take  = 1'h1;
                                            end
                                        end
                                        two_wire_pkg::G_WDATA: begin
                                            n.len = r.len - LEN_ONE;
                                            if (r.len == LEN_ONE) begin
                                                n.st = two_wire_pkg::M_STOP;
                                            end else begin
                                                n.sh   = WR_DATA_I;
                                                n.take = 1'h1;
                                            end
                                        end
                                        two_wire_pkg::G_DEVR: n.stage = two_wire_pkg::G_RDATA;
                                        default: begin
                                            n.rdata  = r.sh;
                                            n.rvalid = 1'h1;
                                            n.len    = r.len - LEN_ONE;
                                            if (r.len == LEN_ONE) begin
                                                n.st = two_wire_pkg::M_STOP;
                                            end
                                        end
                                    endcase
                                end
                            end
                        end
                    endcase
                end
            end
            two_wire_pkg::M_STOP: begin
                if (tick) begin
                    case (r.q)
                        2'h0: n.sda_oe = 1'h1;
                        2'h1: n.scl_oe = 1'h0;
                        2'h2: n.sda_oe = 1'h0;
                        default: begin
                            n.st   = two_wire_pkg::M_IDLE;
                            n.busy = 1'h0;
                            n.done = 1'h1;
                        end
                    endcase
                end
            end
            default: n.st = two_wire_pkg::M_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            r <= '{st: two_wire_pkg::M_IDLE, stage: two_wire_pkg::G_DEVW, q: 2'h0, div: 8'h00,
                   bitn: 4'h0, sh: 8'h00, len: '0, rd: 1'h0, dev: 7'h00, regn: 8'h00, nak: 1'h0,
                   scl_oe: 1'h0, sda_oe: 1'h0, take: 1'h0, rvalid: 1'h0, rdata: 8'h00,
                   busy: 1'h0, done: 1'h0, nack: 1'h0, sda_sy: 2'h3};
        end else begin
            r <= n;
        end
    end

    // lines are pulled low or released, never driven high
    assign BUS.m_scl_o  = 1'h0;
    assign BUS.m_sda_o  = 1'h0;
    assign BUS.m_scl_oe = r.scl_oe;
    assign BUS.m_sda_oe = r.sda_oe;
    assign WR_TAKE_O    = r.take;
    assign RD_DATA_O    = r.rdata;
    assign RD_VALID_O   = r.rvalid;
    assign BUSY_O       = r.busy;
    assign DONE_O       = r.done;
    assign NACK_O       = r.nack;

endmodule

// [verif/two_wire_assertions.sv]
// line checker: timing and ownership relations on the resolved two-wire bus
// assumes one clock domain; signals come straight from the carrier
`timescale 1ns/1ps
module two_wire_assertions (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic m_scl_o,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic s_sda_o,
    input wire logic s_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    a_open_drain: assert property (!m_scl_o && !m_sda_o && !s_sda_o)
        else $error("line driven high");
    // hand-over of the data line happens while the clock is low, so only a high clock is guarded
    a_no_contention: assert property (!(m_sda_oe && s_sda_oe && scl))
        else $error("both ends pull data with clock high");
    a_slave_moves_low: assert property ($changed(s_sda_oe) |-> !scl)
        else $error("slave moved data with clock high");
    a_scl_high_min: assert property ($rose(scl) |=> scl[*8])
        else $error("clock high too short");
    a_scl_low_min: assert property ($fell(scl) |=> !scl[*8])
        else $error("clock low too short");
    a_start_hold: assert property ($fell(sda) && scl |=> scl[*5])
        else $error("start not held");
    a_stop_idle: assert property ($rose(sda) && scl |=> !s_sda_oe[*8])
        else $error("slave drives after stop");
    // slave answers 3 cycles after the clock falls; the check accepts 2 to 4
    a_drive_time: assert property ($rose(s_sda_oe) |-> $past(scl, 5) && !$past(scl, 2))
        else $error("slave drive late or early");
endmodule

// [verif/tb.sv]
// bench: master and slave face each other over the carrier
// assumes a register model answering the slave's address in the same cycle
`timescale 1ns/1ps
module tb;
    logic        CLK_I;
    logic        RST_B_I;
    logic        sel;
    logic        go;
    logic        rd;
    logic [6:0]  dev;
    logic [7:0]  rg;
    logic [3:0]  len;
    logic [7:0]  wdat [4];
    int          widx;
    logic [7:0]  mem [256];
    logic [7:0]  ra;
    logic [7:0]  wd;
    logic [7:0]  rdat;
    logic        we;
    logic        take;
    logic        rv;
    logic        done;
    logic        nack;
    logic        busy;
    logic [15:0] wq [$];
    logic [7:0]  rq [$];
    int          bad_count;
    int          check_count;
    two_wire_if bus ();
    two_wire_master i_two_wire_master (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .BUS(bus.master), .CMD_START_I(go),
        .CMD_READ_I(rd), .CMD_DEV_I(dev), .CMD_REG_I(rg), .CMD_LEN_I(len), .WR_DATA_I(wdat[widx]),
        .WR_TAKE_O(take), .RD_DATA_O(rdat), .RD_VALID_O(rv), .BUSY_O(busy), .DONE_O(done), .NACK_O(nack));
    // 16 registers so a burst can run past the valid range
    two_wire_slave #(.NUM_REGS(16)) i_two_wire_slave (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .BUS(bus.slave),
        .SLAVE_ADDRESS_SELECT_PIN_I(sel), .REG_ADDR_O(ra), .REG_WDATA_O(wd), .REG_WE_O(we),
        .REG_RDATA_I(mem[ra]));
    two_wire_assertions i_two_wire_assertions (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .m_scl_o(bus.m_scl_o),
        .m_sda_o(bus.m_sda_o), .m_sda_oe(bus.m_sda_oe), .s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe),
        .scl(bus.scl), .sda(bus.sda));
    always @(posedge CLK_I) begin
        if (take) widx <= widx + 1;
        if (we) begin
            mem[ra] <= wd;
            wq.push_back({ra, wd});
        end
        if (rv) rq.push_back(rdat);
    end
    initial begin
        CLK_I = 0;
        forever #50 CLK_I = ~CLK_I;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic run(input logic r, input logic [6:0] d, input logic [7:0] a, input logic [3:0] n);
        int k;
        wq.delete();
        rq.delete();
        widx = 0;
        rd = r;
        dev = d;
        rg = a;
        len = n;
        go = 1;
        @(posedge CLK_I);
        #1 go = 0;
        chk({7'h0, busy}, 8'h01);
        k = 0;
        while (done !== 1'b1 && k < 20000) begin
            @(posedge CLK_I);
            #1 k++;
        end
        if (k >= 20000) begin
            bad_count++;
            wrap_up();
        end
        chk({7'h0, busy}, 8'h00);
    endtask
    task automatic t_write();
        wdat = '{8'ha5, 8'h3c, 8'hf0, 8'h00};
        run(1'b0, 7'h6e, 8'h0e, 4'h3);
        chk(8'(wq.size()), 8'h02);
        chk(wq[0][15:8], 8'h0e);
        chk(wq[0][7:0], 8'ha5);
        chk(wq[1][15:8], 8'h0f);
        chk(wq[1][7:0], 8'h3c);
        chk({7'h0, nack}, 8'h00);
    endtask
    task automatic t_read();
        run(1'b1, 7'h6e, 8'h0d, 4'h3);
        chk(8'(rq.size()), 8'h03);
        chk(rq[0], 8'h57);
        chk(rq[1], 8'ha5);
        chk(rq[2], 8'h3c);
        chk({7'h0, nack}, 8'h00);
    endtask
    task automatic t_miss();
        run(1'b0, 7'h6f, 8'h01, 4'h1);
        chk({7'h0, nack}, 8'h01);
        chk(8'(wq.size()), 8'h00);
    endtask
    task automatic t_sel();
        sel = 1;
        repeat (3) @(posedge CLK_I);
        #1 wdat[0] = 8'h96;
        run(1'b0, 7'h6f, 8'h03, 4'h1);
        chk(8'(wq.size()), 8'h01);
        chk(wq[0][7:0], 8'h96);
        run(1'b1, 7'h6e, 8'h03, 4'h1);
        chk({7'h0, nack}, 8'h01);
    endtask
    initial begin
        RST_B_I = 0;
        sel = 0;
        go = 0;
        rd = 0;
        dev = 0;
        rg = 0;
        len = 0;
        widx = 0;
        wdat = '{default: 8'h00};
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
        repeat (2) @(posedge CLK_I);
        #1 RST_B_I = 1;
        repeat (3) @(posedge CLK_I);
        #1 t_write();
        t_read();
        t_miss();
        t_sel();
        wrap_up();
    end
endmodule
